// file: hw/tsr_top.v
`include "tsr_regs.vh"
// ********************************************************************
// trigger timestamp recorder top
// ********************************************************************
module tsr_top #(
  parameter DEPTH = `TSR_FIFO_DEPTH,
  parameter AW    = 2
) (
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   stamp_clear,   // reset command pulse
  input  wire                   ref_mode,      // seconds-pulse mode
  input  wire                   pps_in,        // 1 Hz reference
  input  wire                   trig_in,       // external trigger
  input  wire                   acq_start,     // new acquisition arm
  output reg                    trig_out,      // trigger output
  output reg                    rd_valid,      // host word present
  input  wire                   rd_ready,      // host takes word
  output reg  [`TSR_STAMP_W-1:0] rd_data,      // host word
  output reg                    fifo_empty,
  output reg                    fifo_full,
  output reg                    stamp_lost     // trigger hit full fifo
);
  // ******************************************************************
  // counters
  // ******************************************************************
  reg  [`TSR_STAMP_W-1:0] cnt_q;     // free running stamp
  reg  [`TSR_HALF_W-1:0]  sec_q;     // whole seconds
  reg  [`TSR_HALF_W-1:0]  sub_q;     // samples since pulse
  reg                     pps_q;     // pulse delayed for edge
  reg  [1:0]              trg_q;     // trigger history
  reg                     fired_q;   // first trigger seen
  reg                     lost_q;
  wire                    pps_rise;
  wire                    trg_evt;
  wire [`TSR_STAMP_W-1:0] stamp;
  wire                    in_ready;
  wire                    f_valid;
  wire [`TSR_STAMP_W-1:0] f_data;
  wire                    f_empty;
  wire                    f_full;

  // pulse edge; inputs are synchronous so no extra stage
  assign pps_rise = pps_in & ~pps_q;
  // trigger recognised after two high samples, source keeps it there
  assign trg_evt  = trig_in & trg_q[0] & ~trg_q[1];

  // stamp counter, clear command wins over counting
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= {`TSR_STAMP_W{1'b0}};
    else if (stamp_clear)
      cnt_q <= {`TSR_STAMP_W{1'b0}};
    else
      cnt_q <= cnt_q + 1'b1;
  end

  // reference mode seconds and sub-second halves
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sec_q <= {`TSR_HALF_W{1'b0}};
      sub_q <= {`TSR_HALF_W{1'b0}};
      pps_q <= 1'b0;
    end
    else
    begin
      pps_q <= pps_in;
      if (stamp_clear)
      begin
        sec_q <= {`TSR_HALF_W{1'b0}};
        sub_q <= {`TSR_HALF_W{1'b0}};
      end
      else if (pps_rise)
      begin
        sec_q <= sec_q + 1'b1;
        sub_q <= {`TSR_HALF_W{1'b0}};
      end
      else
        sub_q <= sub_q + 1'b1;
    end
  end

  // choose stamp form: seconds high, sub-second low
  assign stamp = ref_mode ? {sec_q, sub_q} : cnt_q;

  // trigger history and output edge, one per acquisition
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trg_q    <= 2'b00;
      fired_q  <= 1'b0;
      trig_out <= 1'b0;
      lost_q   <= 1'b0;
    end
    else
    begin
      trg_q <= {trg_q[0], trig_in};
      if (acq_start)
      begin
        fired_q  <= 1'b0;
        trig_out <= 1'b0;
      end
      else if (trg_evt & ~fired_q)
      begin
        fired_q  <= 1'b1;
        trig_out <= 1'b1;
      end
      // sticky loss flag, cleared by the reset command; set wins
      if (trg_evt & ~in_ready)
        lost_q <= 1'b1;
      else if (stamp_clear)
        lost_q <= 1'b0;
    end
  end

  // ******************************************************************
  // stamp fifo, drained by host at its own pace
  // ******************************************************************
  tsr_fifo #(
    .WIDTH (`TSR_STAMP_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (trg_evt),
    .in_ready  (in_ready),
    .in_data   (stamp),
    .out_valid (f_valid),
    .out_ready (rd_ready & rd_valid & ~f_empty),
    .out_data  (f_data),
    .empty     (f_empty),
    .full      (f_full)
  );

  // registered outputs; the host word trails the fifo head by a cycle,
  // so after each pop the word is hidden for one cycle while the next
  // head settles into rd_data
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_valid   <= 1'b0;
      rd_data    <= {`TSR_STAMP_W{1'b0}};
      fifo_empty <= 1'b1;
      fifo_full  <= 1'b0;
      stamp_lost <= 1'b0;
    end
    else
    begin
      fifo_empty <= f_empty;
      fifo_full  <= f_full;
      stamp_lost <= lost_q;
      // host took the word: drop valid, the head advances meanwhile
      if (rd_ready & rd_valid)
        rd_valid <= 1'b0;
      else
      // mirror the head, which only moves on a pop
      begin
        rd_valid <= f_valid;
        rd_data  <= f_data;
      end
    end
  end
endmodule // tsr_top

// ********************************************************************
// small flop fifo, valid/ready on both sides
// ********************************************************************
module tsr_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             empty,
  output wire             full
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage flops
  reg [AW-1:0]    wr_q;              // write index
  reg [AW-1:0]    rd_q;              // read index
  reg [AW:0]      cnt_q;             // fill level
  wire push;
  wire pop;
  // full refuses the push, stored words stay intact
  assign full      = (cnt_q == DEPTH[AW:0]);
  assign empty     = (cnt_q == {(AW+1){1'b0}});
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;
  // pointer and level bookkeeping
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
  // data write, no reset needed on storage
  always @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end
endmodule // tsr_fifo

// file: hw/tsr_regs.vh
// What this block does
// - reset command clears timestamp counter to zero
// - counter advances once every sample clock
// - each trigger pushes counter value into fifo unless full
// - host reads fifo without disturbing sampling
// - reference mode aligns counter to seconds pulse
// - reference stamp is 64 bits, seconds and sub
// - seconds count pulses since last reset command
// - sub-second clears on pulse edge, counts samples
// - one rising trigger output edge per acquisition
`ifndef TSR_REGS_VH
`define TSR_REGS_VH
// ********************************************************************
// stamp layout and fifo shape
// ********************************************************************
`define TSR_STAMP_W    64
`define TSR_HALF_W     32
`define TSR_FIFO_DEPTH 4
`define TSR_TRIG_HOLD  2
`endif

// file: hw/tsr_fifo.v
// ********************************************************************
// the stamp fifo module sits in tsr_top.v, beside the top module
// ********************************************************************

// file: verif/tsr_chk.sv
`include "tsr_regs.vh"
// watches the top ports only
module tsr_chk (
  input wire                    clk,
  input wire                    rst,
  input wire                    stamp_clear,
  input wire                    trig_in,
  input wire                    acq_start,
  input wire                    trig_out,
  input wire                    rd_valid,
  input wire                    rd_ready,
  input wire [`TSR_STAMP_W-1:0] rd_data,
  input wire                    fifo_empty,
  input wire                    fifo_full,
  input wire                    stamp_lost
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // one domain, so one clocking
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_HOLD: assert property (rd_valid && !rd_ready |=>
    rd_valid && $stable(rd_data)) else $error("word lost");
  AST_GAP: assert property (rd_valid && rd_ready |=> !rd_valid)
    else $error("no gap");
  AST_ROSE: assert property ($rose(rd_valid) |-> !fifo_empty)
    else $error("word from empty");
  AST_NOBOTH: assert property (!(fifo_full && fifo_empty))
    else $error("full and empty");
  AST_FELL: assert property ($fell(fifo_empty) |-> ##[0:2] rd_valid)
    else $error("stamp not shown");
  AST_TFALL: assert property ($fell(trig_out) |->
    $past(acq_start) || $past(acq_start, 2)) else $error("trig dropped");
  AST_TROSE: assert property ($rose(trig_out) |->
    $past(trig_in) || $past(trig_in, 2)) else $error("trig uncaused");
  // clear may land a cycle late, so both cycles are excused
  AST_LSTICK: assert property (stamp_lost && !stamp_clear &&
    !$past(stamp_clear) |=> stamp_lost) else $error("lost cleared");
  AST_LFULL: assert property ($rose(stamp_lost) |-> $past(fifo_full) &&
    $past(trig_in, 2)) else $error("lost not full");
endmodule // tsr_chk

// file: verif/tsr_partner.sv
// trigger source, seconds pulse and host readout
module tsr_partner (
  input  wire        clk,
  input  wire        rd_valid,
  input  wire [63:0] rd_data,
  output logic       trig_in,
  output logic       pps_in,
  output logic       rd_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    trig_in = 1'b0;
    pps_in = 1'b0;
    rd_ready = 1'b0;
  end
  // called at a falling edge; one low sample closes the pulse
  task automatic trig(input int n);
    trig_in = 1'b1;
    repeat (n) @(negedge clk);
    trig_in = 1'b0;
    @(negedge clk);
  endtask
  task automatic pps();
    pps_in = 1'b1;
    repeat (2) @(negedge clk);
    pps_in = 1'b0;
    @(negedge clk);
  endtask
  // host pop, bounded so a stuck fifo cannot hang the run
  task automatic pop(output logic [63:0] d, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++)
    begin
      if (rd_valid === 1'b1)
      begin
        d = rd_data;
        rd_ready = 1'b1;
        ok = 1'b1;
      end
      @(negedge clk);
    end
    rd_ready = 1'b0;
  endtask
endmodule // tsr_partner

// file: verif/tsr_top_tb.sv
`include "tsr_regs.vh"
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t %h %h", $time, (a), (b)); end end
module tsr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, stamp_clear, ref_mode, acq_start, ok;
  wire  trig_in, pps_in, rd_ready, trig_out, rd_valid;
  wire  fifo_empty, fifo_full, stamp_lost;
  wire  [`TSR_STAMP_W-1:0] rd_data;
  logic [63:0] a, b;
  int   errors, check_count, cyc, t0, g, n;
  tsr_top tsr_top_i (.clk(clk), .rst(rst), .stamp_clear(stamp_clear),
    .ref_mode(ref_mode), .pps_in(pps_in), .trig_in(trig_in),
    .acq_start(acq_start), .trig_out(trig_out), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .fifo_empty(fifo_empty),
    .fifo_full(fifo_full), .stamp_lost(stamp_lost));
  tsr_partner tsr_partner_i (.clk(clk), .rd_valid(rd_valid),
    .rd_data(rd_data), .trig_in(trig_in), .pps_in(pps_in),
    .rd_ready(rd_ready));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cycle count gives expected stamp distances
  always @(posedge clk) cyc <= cyc + 1;
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // stamps of two triggers differ by the cycles between their calls
  function automatic longint exp_gap(input int n, input int g);
    return n + 1 + g;
  endfunction
  // sub-second count seen by a trigger called g cycles after a pulse
  function automatic logic [31:0] exp_sub(input int g);
    return g + 3;
  endfunction
  task automatic take(output logic [63:0] d);
    tsr_partner_i.pop(d, ok);
    `CK(ok, 1'b1)
    if (!ok)
      wrap_up();
  endtask
  task automatic clear();
    stamp_clear = 1'b1;
    @(negedge clk);
    stamp_clear = 1'b0;
  endtask
  initial
  begin
    {errors, check_count, cyc} = 0;
    {rst, stamp_clear, ref_mode, acq_start} = 4'h8;
    void'($urandom(32'h74af30ce));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    `CK(fifo_empty, 1'b1)
    // same delay after a clear must give the same stamp
    for (int k = 0; k < 2; k++)
    begin
      clear();
      repeat (5) @(negedge clk);
      tsr_partner_i.trig(2 + k);
      take(b);
      if (k == 0) a = b;
    end
    `CK(a, b)
    `CK(trig_out, 1'b1)
    acq_start = 1'b1;
    @(negedge clk);
    acq_start = 1'b0;
    @(negedge clk);
    `CK(trig_out, 1'b0)
    repeat (4)
    begin
      g = 3 + $urandom % 40;
      n = 2 + $urandom % 3;
      t0 = cyc;
      tsr_partner_i.trig(n);
      repeat (g) @(negedge clk);
      t0 = cyc - t0;
      tsr_partner_i.trig(2);
      take(a);
      take(b);
      `CK(b - a, 64'(t0))
      `CK(b - a, exp_gap(n, g))
    end
    `CK(trig_out, 1'b1)
    // host stalls while six triggers land, three cycles apart
    repeat (6) tsr_partner_i.trig(2);
    @(negedge clk);
    `CK(fifo_full, 1'b1)
    `CK(stamp_lost, 1'b1)
    take(b);
    for (int k = 0; k < 3; k++)
    begin
      a = b;
      take(b);
      `CK(b - a, 64'h3)
    end
    tsr_partner_i.pop(a, ok);
    `CK(ok, 1'b0)
    `CK(fifo_empty, 1'b1)
    clear();
    @(negedge clk);
    `CK(stamp_lost, 1'b0)
    ref_mode = 1'b1;
    g = 3 + $urandom % 20;
    clear();
    for (int k = 0; k < 2; k++)
    begin
      tsr_partner_i.pps();
      repeat (g) @(negedge clk);
      tsr_partner_i.trig(2);
      take(b);
      if (k == 0) a = b;
    end
    `CK(a[63:32], 32'h1)
    `CK(b[63:32], 32'h2)
    `CK(a[31:0], b[31:0])
    `CK(a[31:0], exp_sub(g))
    wrap_up();
  end
endmodule // tsr_top_tb
bind tsr_top tsr_chk tsr_chk_i (.clk(clk), .rst(rst),
  .stamp_clear(stamp_clear), .trig_in(trig_in), .acq_start(acq_start),
  .trig_out(trig_out), .rd_valid(rd_valid), .rd_ready(rd_ready),
  .rd_data(rd_data), .fifo_empty(fifo_empty), .fifo_full(fifo_full),
  .stamp_lost(stamp_lost));
